//--- design/j1850_pkg.sv
// Purpose: Shared constants and types for the link CPU interface block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes: Source codes sit in bits 5:2 of the state vector register
package j1850_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_VECTOR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Field positions
  localparam int VEC_LSB = 2;
  localparam int CTL1_IE_BIT = 0;
  localparam int CTL1_WCM_BIT = 1;
  localparam int CTL2_TRANSMIT_END_OF_DATA_BIT_BIT = 0;
  // Reset values
  localparam logic [1:0] CTRL_ONE_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Interrupt source codes, higher is higher priority
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_EOF = 4'h1;
  localparam logic [3:0] SRC_IFR = 4'h2;
  localparam logic [3:0] SRC_RXFULL = 4'h3;
  localparam logic [3:0] SRC_TXEMPTY = 4'h4;
  localparam logic [3:0] SRC_ARB = 4'h5;
  localparam logic [3:0] SRC_CRC = 4'h6;
  localparam logic [3:0] SRC_INVSYM = 4'h7;
  localparam logic [3:0] SRC_WAKEUP = 4'h8;
  localparam int NUM_SRC = 8;
  // Timing: clock restart settle time after stop wake-up
  localparam int CLK_NS = 5;
  localparam int STAB_NS = 80;
  localparam int STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [1:0] TAIL_BITS = 2'h2;
  // Events from the symbol layer, same clock
  typedef struct packed {
    logic byte_valid;
    logic is_ifr;
    logic [7:0] data;
    logic eof;
    logic arb_lost;
    logic crc_err;
    logic sym_invalid;
    logic busy;
  } rx_evt_t;
  // Power modes, Gray along run-wait-stop-wake
  typedef enum logic [1:0] {
    M_RUN = 2'b00,
    M_WAIT = 2'b01,
    M_STOP = 2'b11,
    M_WAKE = 2'b10
  } mode_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_SHIFT = 2'b01,
    T_TAIL = 2'b11
  } tx_state_t;
endpackage

//--- design/j1850_link_cpu.sv
// Purpose: CPU side of a J1850 byte link: vector, data buffers, low power
// Assumes: Symbol layer supplies events and bit ticks on clk
// Notes: Bus pin is asynchronous and synchronised here
//
// Behaviour
// - Vector read clears code except data sources
// - Receive flags clear by vector then data read
// - Transmit empty clears by vector+write or end-of-data
// - Vector value steps by four per source
// - Remaining lower source shown after clearing higher
// - Data read returns last received byte
// - Shadow byte moves into shift register
// - Transmit empty set after first bit sent
// - Completed byte into shadow, set receive full
// - Underrun stops transmit after two ones
// - Underrun abort reported as invalid symbol
// - Wait entered with clock-mode clear; no driving
// - Received message wakes from wait, interrupt
// - Stop entered by STOP or WAIT with bit
// - Bus activity wakes from stop, nonmaskable interrupt
// - Stop via wait keeps byte if frame ended
// - Stop during reception wakes on first edge
// - Pending source encoded by priority
`timescale 1ns/1ps
module j1850_link_cpu (
  input wire logic clk, // 200 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [7:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  input wire j1850_pkg::rx_evt_t rx_evt, // Symbol layer events
  input wire logic tx_bit_tick, // One pulse per bit time
  output logic tx_bit, // Bit to send
  output logic tx_drive, // Transmitter may drive bus
  output logic tx_eod, // End-of-data request pulse
  input wire logic bus_pin, // Raw bus level, high is active
  input wire logic cpu_wait_exec, // CPU executed WAIT, pulse
  input wire logic cpu_stop_exec, // CPU executed STOP, pulse
  output logic irq_req, // Maskable interrupt request
  output logic nmi_req, // Nonmaskable wake pulse
  output logic clocks_run // Internal clocks running
);
  import j1850_pkg::*;

  // ----------------------------------------------------------------
  // Priority encoder
  // ----------------------------------------------------------------
  function automatic logic [3:0] top_source(input logic [NUM_SRC:1] f);
    logic [3:0] c;
    c = SRC_NONE;
    for (int i = 1; i <= NUM_SRC; i++) begin
      if (f[i]) begin
        c = 4'(i);
      end
    end
    return c;
  endfunction

  logic ack_q;
  logic [31:0] rdata_q;
  logic [3:0] rd_code_q;
  logic [NUM_SRC:1] flag_q;
  logic [NUM_SRC:1] set_s;
  logic [NUM_SRC:1] clr_s;
  logic [3:0] code;
  logic arm_rx_q, arm_tx_q;
  logic [1:0] ctrl_one_q;
  logic transmit_end_of_data_bit_q;
  logic [7:0] rx_shadow_q, tx_shadow_q, shift_q;
  logic shadow_full_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] tail_cnt_q;
  tx_state_t tx_q;
  mode_t mode_q;
  logic stop_ok_q, stop_busy_q, eof_seen_q;
  logic [7:0] stab_q;
  logic sync1_q, sync2_q, sync3_q;
  logic acc, vec_rd, dat_rd, dat_wr, c1_wr, c2_wr;
  logic rx_ok, bus_rise, bus_edge, underrun, run;

  // ----------------------------------------------------------------
  // Avalon slave, one wait cycle per access
  // ----------------------------------------------------------------
  assign waitrequest = (read | write) & ~ack_q;
  assign acc = (read | write) & ack_q;
  assign vec_rd = acc & read & (address == OFS_VECTOR);
  assign dat_rd = acc & read & (address == OFS_DATA);
  assign dat_wr = acc & write & (address == OFS_DATA);
  assign c1_wr = acc & write & (address == OFS_CTRL_ONE);
  assign c2_wr = acc & write & (address == OFS_CTRL_TWO);
  assign readdata = rdata_q;
  assign code = top_source(flag_q);
  assign run = (mode_q == M_RUN);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
      rd_code_q <= SRC_NONE;
    end else if ((read | write) & ~ack_q) begin
      rdata_q <= 32'h0;
      rd_code_q <= code;
      if (read) begin
        case (address)
          OFS_VECTOR: rdata_q[VEC_LSB +: 4] <= code;
          OFS_DATA: rdata_q[7:0] <= rx_shadow_q;
          OFS_CTRL_ONE: rdata_q[1:0] <= ctrl_one_q;
          OFS_CTRL_TWO: rdata_q[CTL2_TRANSMIT_END_OF_DATA_BIT_BIT] <= transmit_end_of_data_bit_q;
          OFS_STATUS: rdata_q[7:0] <= {tx_q, mode_q, 1'b0, shadow_full_q, arm_tx_q, arm_rx_q};
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_one_q <= CTRL_ONE_RST;
    end else if (c1_wr) begin
      ctrl_one_q <= writedata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      transmit_end_of_data_bit_q <= 1'b0;
    end else if (c2_wr & writedata[CTL2_TRANSMIT_END_OF_DATA_BIT_BIT]) begin
      transmit_end_of_data_bit_q <= 1'b1;
    end else if (tx_q == T_IDLE && !shadow_full_q) begin
      transmit_end_of_data_bit_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt source flags
  // ----------------------------------------------------------------
  assign rx_ok = run || (mode_q == M_WAIT) || (mode_q == M_STOP && stop_ok_q);
  assign underrun = (tx_q == T_SHIFT) & tx_bit_tick & (bit_cnt_q == BIT_LAST)
                    & ~shadow_full_q & ~transmit_end_of_data_bit_q;

  always_comb begin
    set_s = '0;
    set_s[SRC_EOF] = rx_evt.eof & rx_ok;
    set_s[SRC_IFR] = rx_evt.byte_valid & rx_evt.is_ifr & rx_ok;
    set_s[SRC_RXFULL] = rx_evt.byte_valid & ~rx_evt.is_ifr & rx_ok;
    set_s[SRC_TXEMPTY] = (tx_q == T_SHIFT) & tx_bit_tick & (bit_cnt_q == 4'h0)
                         & ~transmit_end_of_data_bit_q & run;
    set_s[SRC_ARB] = rx_evt.arb_lost & rx_ok;
    set_s[SRC_CRC] = rx_evt.crc_err & rx_ok;
    set_s[SRC_INVSYM] = (rx_evt.sym_invalid & rx_ok)
                        | ((tx_q == T_TAIL) & tx_bit_tick & (tail_cnt_q == TAIL_BITS - 2'h1));
    set_s[SRC_WAKEUP] = (mode_q == M_STOP) & (stop_busy_q ? bus_edge : bus_rise);
  end

  always_comb begin
    clr_s = '0;
    if (vec_rd && rd_code_q != SRC_IFR && rd_code_q != SRC_RXFULL
        && rd_code_q != SRC_TXEMPTY && rd_code_q != SRC_NONE) begin
      clr_s[rd_code_q] = 1'b1;
    end
    if (dat_rd && arm_rx_q) begin
      clr_s[SRC_IFR] = 1'b1;
      clr_s[SRC_RXFULL] = 1'b1;
    end
    // write after vector read, or end-of-data
    if ((dat_wr && arm_tx_q) || (c2_wr && writedata[CTL2_TRANSMIT_END_OF_DATA_BIT_BIT])) begin
      clr_s[SRC_TXEMPTY] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~clr_s) | set_s;
    end
  end

  // arm on vector read of data source
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arm_rx_q <= 1'b0;
      arm_tx_q <= 1'b0;
    end else begin
      if (vec_rd && (rd_code_q == SRC_IFR || rd_code_q == SRC_RXFULL)) begin
        arm_rx_q <= 1'b1;
      end else if (dat_rd) begin
        arm_rx_q <= 1'b0;
      end
      if (vec_rd && rd_code_q == SRC_TXEMPTY) begin
        arm_tx_q <= 1'b1;
      end else if (dat_wr || clr_s[SRC_TXEMPTY]) begin
        arm_tx_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive shadow
  // ----------------------------------------------------------------
  // overwrite with newest byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_shadow_q <= BYTE_RST;
    end else if (rx_evt.byte_valid & rx_ok) begin
      rx_shadow_q <= rx_evt.data;
    end
  end

  // ----------------------------------------------------------------
  // Transmit shadow and shift register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_shadow_q <= BYTE_RST;
      shadow_full_q <= 1'b0;
    end else if (dat_wr && run) begin
      tx_shadow_q <= writedata[7:0];
      shadow_full_q <= 1'b1;
    end else if (shadow_full_q && run && (tx_q == T_IDLE || (tx_q == T_SHIFT
                 && tx_bit_tick && bit_cnt_q == BIT_LAST))) begin
      shadow_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_q <= T_IDLE;
      shift_q <= BYTE_RST;
      bit_cnt_q <= 4'h0;
      tail_cnt_q <= 2'h0;
      tx_bit <= 1'b0;
      tx_eod <= 1'b0;
    end else begin
      tx_eod <= 1'b0;
      if (!run) begin
        tx_q <= T_IDLE;
      end else begin
        case (tx_q)
          T_IDLE: begin
            if (shadow_full_q) begin
              shift_q <= tx_shadow_q;
              bit_cnt_q <= 4'h0;
              tx_q <= T_SHIFT;
            end
          end
          T_SHIFT: begin
            if (tx_bit_tick) begin
              tx_bit <= shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == BIT_LAST) begin
                if (shadow_full_q) begin
                  shift_q <= tx_shadow_q;
                  bit_cnt_q <= 4'h0;
                end else if (transmit_end_of_data_bit_q) begin
                  tx_eod <= 1'b1;
                  tx_q <= T_IDLE;
                end else begin
                  tail_cnt_q <= 2'h0;
                  tx_q <= T_TAIL;
                end
              end
            end
          end
          T_TAIL: begin
            if (tx_bit_tick) begin
              tx_bit <= 1'b1;
              tail_cnt_q <= tail_cnt_q + 2'h1;
              if (tail_cnt_q == TAIL_BITS - 2'h1) begin
                tx_q <= T_IDLE;
              end
            end
          end
          default: tx_q <= T_IDLE;
        endcase
      end
    end
  end

  assign tx_drive = run & (tx_q != T_IDLE);

  // ----------------------------------------------------------------
  // Bus pin synchroniser and edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= bus_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign bus_rise = sync2_q & ~sync3_q;
  assign bus_edge = sync2_q ^ sync3_q;

  // ----------------------------------------------------------------
  // Low-power modes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eof_seen_q <= 1'b1;
    end else if (rx_evt.eof) begin
      eof_seen_q <= 1'b1;
    end else if (rx_evt.busy | rx_evt.byte_valid) begin
      eof_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= M_RUN;
      stop_ok_q <= 1'b0;
      stop_busy_q <= 1'b0;
      stab_q <= 8'h0;
      nmi_req <= 1'b0;
    end else begin
      nmi_req <= 1'b0;
      case (mode_q)
        M_RUN: begin
          stop_busy_q <= rx_evt.busy;
          if (cpu_stop_exec) begin
            stop_ok_q <= 1'b0;
            mode_q <= M_STOP;
          end else if (cpu_wait_exec && ctrl_one_q[CTL1_WCM_BIT]) begin
            stop_ok_q <= eof_seen_q & ~rx_evt.busy;
            mode_q <= M_STOP;
          end else if (cpu_wait_exec) begin
            mode_q <= M_WAIT;
          end
        end
        M_WAIT: begin
          if (rx_evt.eof) begin
            mode_q <= M_RUN;
          end
        end
        M_STOP: begin
          if (stop_busy_q ? bus_edge : bus_rise) begin
            nmi_req <= 1'b1;
            stab_q <= 8'(STAB_CYC);
            mode_q <= M_WAKE;
          end
        end
        M_WAKE: begin
          if (stab_q <= 8'h1) begin
            mode_q <= M_RUN;
          end
          stab_q <= stab_q - 8'h1;
        end
        default: mode_q <= M_RUN;
      endcase
    end
  end

  assign clocks_run = (mode_q != M_STOP);
  assign irq_req = ctrl_one_q[CTL1_IE_BIT] & (code != SRC_NONE) & (mode_q != M_STOP);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_vec_rx;
    vec_rd && (rd_code_q == SRC_RXFULL);
  endsequence
  sequence s_dat_rd;
    dat_rd && arm_rx_q && !set_s[SRC_RXFULL];
  endsequence
  sequence s_tail_end;
    run && tx_q == T_TAIL && tx_bit_tick && tail_cnt_q == TAIL_BITS - 2'h1;
  endsequence
  property p_keep_data;
    @(posedge clk) disable iff (sys_rst)
    vec_rd && rd_code_q == SRC_TXEMPTY |=> flag_q[SRC_TXEMPTY];
  endproperty
  a_keep_data: assert property (p_keep_data) else $error("tx empty lost on read");
  property p_rx_arm;
    @(posedge clk) disable iff (sys_rst)
    s_vec_rx |=> arm_rx_q;
  endproperty
  a_rx_arm: assert property (p_rx_arm) else $error("rx not armed by vector read");
  property p_rx_clear;
    @(posedge clk) disable iff (sys_rst)
    s_dat_rd |=> !flag_q[SRC_RXFULL];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx full not cleared");
  property p_rx_noarm;
    @(posedge clk) disable iff (sys_rst)
    dat_rd && !arm_rx_q && flag_q[SRC_RXFULL] |=> flag_q[SRC_RXFULL];
  endproperty
  a_rx_noarm: assert property (p_rx_noarm) else $error("rx full cleared early");
  property p_transmit_end_of_data_bit_clear;
    @(posedge clk) disable iff (sys_rst)
    c2_wr && writedata[CTL2_TRANSMIT_END_OF_DATA_BIT_BIT] && !set_s[SRC_TXEMPTY] |=> !flag_q[SRC_TXEMPTY];
  endproperty
  a_transmit_end_of_data_bit_clear: assert property (p_transmit_end_of_data_bit_clear) else $error("transmit_end_of_data_bit left tx empty");
  property p_vec_mult4;
    @(posedge clk) disable iff (sys_rst)
    ack_q && read && address == OFS_VECTOR |-> readdata[1:0] == 2'h0
      && readdata[31:6] == 26'h0;
  endproperty
  a_vec_mult4: assert property (p_vec_mult4) else $error("vector not multiple of 4");
  property p_empty_first;
    @(posedge clk) disable iff (sys_rst)
    run && tx_q == T_SHIFT && tx_bit_tick && bit_cnt_q == 4'h0 && !transmit_end_of_data_bit_q
      |=> flag_q[SRC_TXEMPTY];
  endproperty
  a_empty_first: assert property (p_empty_first) else $error("tx empty not set");
  property p_rx_load;
    @(posedge clk) disable iff (sys_rst)
    rx_evt.byte_valid && !rx_evt.is_ifr && run
      |=> rx_shadow_q == $past(rx_evt.data) && flag_q[SRC_RXFULL];
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("rx byte not stored");
  property p_tail;
    @(posedge clk) disable iff (sys_rst)
    underrun && run |=> tx_q == T_TAIL;
  endproperty
  a_tail: assert property (p_tail) else $error("underrun not tailed");
  property p_tail_end;
    @(posedge clk) disable iff (sys_rst)
    s_tail_end |=> tx_q == T_IDLE && tx_bit && flag_q[SRC_INVSYM];
  endproperty
  a_tail_end: assert property (p_tail_end) else $error("tail end not reported");
  property p_no_drive;
    @(posedge clk) disable iff (sys_rst)
    mode_q == M_WAIT |-> !tx_drive;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("drive in wait");
  property p_stop_wake;
    @(posedge clk) disable iff (sys_rst)
    mode_q == M_STOP && bus_rise |=> nmi_req && mode_q == M_WAKE;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake missed");
  property p_busy_wake;
    @(posedge clk) disable iff (sys_rst)
    mode_q == M_STOP && stop_busy_q && bus_edge |=> nmi_req && mode_q == M_WAKE;
  endproperty
  a_busy_wake: assert property (p_busy_wake) else $error("busy stop wake missed");
  property p_wait_wake;
    @(posedge clk) disable iff (sys_rst)
    mode_q == M_WAIT && rx_evt.eof |=> mode_q == M_RUN;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("wait wake missed");
  property p_wait_enter;
    @(posedge clk) disable iff (sys_rst)
    run && cpu_wait_exec && !cpu_stop_exec |=>
      mode_q == ($past(ctrl_one_q[CTL1_WCM_BIT]) ? M_STOP : M_WAIT);
  endproperty
  a_wait_enter: assert property (p_wait_enter) else $error("wrong low power mode");
endmodule

//--- verif/j1850_bus_node.sv
// Purpose: Far-side bus node and symbol layer stand-in
// Assumes: Events and bit ticks share clk
// Notes: Bit tick is free running, one every TICK cycles
`timescale 1ns/1ps
module j1850_bus_node #(
  parameter int TICK = 4
) (
  input wire logic clk, // Clock
  output j1850_pkg::rx_evt_t rx_evt, // Receive events
  output logic tx_bit_tick, // Bit time pulse
  output logic bus_pin // Bus level, high active
);
  import j1850_pkg::*;
  int cnt = 0;
  initial begin
    rx_evt = '0;
    tx_bit_tick = 1'b0;
    bus_pin = 1'b0;
  end
  always @(posedge clk) begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    tx_bit_tick <= (cnt == TICK - 1);
  end
  // One-cycle event; data line then shows the inverse
  task automatic put(input rx_evt_t e);
    rx_evt_t idle;
    idle = '0;
    idle.busy = e.busy;
    idle.data = ~e.data;
    @(posedge clk);
    rx_evt <= e;
    @(posedge clk);
    rx_evt <= idle;
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    bus_pin <= v;
  endtask
endmodule

//--- verif/j1850_link_cpu_vector_buffer_bench.sv
// Purpose: Self-checking bench for the link CPU interface
// Assumes: Avalon answers after one wait cycle
// Notes: Random bytes from a fixed seed
`timescale 1ns/1ps
module j1850_link_cpu_vector_buffer_bench;
  import j1850_pkg::*;
  localparam int TICK = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  rx_evt_t rx_evt;
  logic tx_bit_tick, tx_bit, tx_drive, tx_eod, bus_pin;
  logic cpu_wait_exec = 1'b0;
  logic cpu_stop_exec = 1'b0;
  logic irq_req, nmi_req, clocks_run;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int t, n;
  logic [31:0] rd;
  logic [7:0] b;
  logic tk_q = 1'b0;
  logic [7:0] sh_q = 8'h00;

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Collect each sent bit, MSB first
  always @(posedge clk) tk_q <= tx_bit_tick & tx_drive;
  always @(negedge clk) begin
    if (tk_q) begin
      sh_q <= {sh_q[6:0], tx_bit};
    end
  end

  j1850_link_cpu dut (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rx_evt(rx_evt), .tx_bit_tick(tx_bit_tick), .tx_bit(tx_bit), .tx_drive(tx_drive),
    .tx_eod(tx_eod), .bus_pin(bus_pin), .cpu_wait_exec(cpu_wait_exec),
    .cpu_stop_exec(cpu_stop_exec), .irq_req(irq_req), .nmi_req(nmi_req),
    .clocks_run(clocks_run));
  j1850_bus_node #(.TICK(TICK)) node (.clk(clk), .rx_evt(rx_evt),
    .tx_bit_tick(tx_bit_tick), .bus_pin(bus_pin));

  // ----------------------------------------
  // Checks and bus cycles
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic flag(input string what, input logic exp, ref logic sig);
    repeat (2) @(negedge clk);
    chk(what, {31'h0, exp}, {31'h0, sig});
  endtask
  function automatic logic [31:0] vexp(input logic [3:0] c);
    return {26'h0, c, 2'h0};
  endfunction
  function automatic logic [3:0] code_of(input int k);
    logic [3:0] m [6] = '{SRC_RXFULL, SRC_IFR, SRC_EOF, SRC_ARB, SRC_CRC, SRC_INVSYM};
    return m[k];
  endfunction
  function automatic rx_evt_t mk(input int k, input logic [7:0] d);
    rx_evt_t e;
    e = '0;
    e.data = d;
    e.byte_valid = (k <= 1);
    e.is_ifr = (k == 1);
    e.eof = (k == 2);
    e.arb_lost = (k == 3);
    e.crc_err = (k == 4);
    e.sym_invalid = (k == 5);
    e.busy = (k != 2);
    return e;
  endfunction
  // Request held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    logic w;
    int k;
    k = 0;
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(negedge clk);
      w = waitrequest;
      q = readdata;
      @(posedge clk);
      k++;
    end while (w !== 1'b0 && k < 50);
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 50) begin
      chk("waitrequest", 32'h0, {31'h0, w});
      give_verdict();
    end
  endtask
  task automatic vec_is(input logic [3:0] c);
    bus(1'b0, OFS_VECTOR, 32'h0, rd);
    chk("vector", vexp(c), rd);
  endtask
  task automatic wait_vec(input logic [3:0] c);
    int k;
    k = 0;
    do begin
      bus(1'b0, OFS_VECTOR, 32'h0, rd);
      k++;
    end while (rd !== vexp(c) && k < 200);
    chk("vector wait", vexp(c), rd);
    if (k >= 200) give_verdict();
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n = $urandom(53615);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    vec_is(SRC_NONE);
    bus(1'b0, OFS_CTRL_ONE, 32'h0, rd);
    chk("ctrl one", {30'h0, CTRL_ONE_RST}, rd);
    bus(1'b0, 8'h3c, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int k = 0; k < 6; k++) begin
      b = 8'($urandom);
      node.put(mk(k, b));
      wait_vec(code_of(k));
      if (k <= 1) begin
        vec_is(code_of(k));
        bus(1'b0, OFS_DATA, 32'h0, rd);
        chk("rx data", {24'h0, b}, rd);
        vec_is(SRC_NONE);
      end else begin
        vec_is(SRC_NONE);
      end
    end
    node.put(mk(0, 8'h5a));
    b = 8'($urandom);
    node.put(mk(0, b));
    node.put(mk(2, 8'h00));
    wait_vec(SRC_RXFULL);
    bus(1'b0, OFS_DATA, 32'h0, rd);
    chk("rx newest", {24'h0, b}, rd);
    vec_is(SRC_EOF);
    vec_is(SRC_NONE);
    b = 8'($urandom);
    bus(1'b1, OFS_DATA, {24'h0, b}, rd);
    wait_vec(SRC_TXEMPTY);
    flag("tx drive", 1'b1, tx_drive);
    bus(1'b1, OFS_DATA, {24'h0, ~b}, rd);
    vec_is(SRC_NONE);
    wait_vec(SRC_TXEMPTY);
    t = cyc;
    wait_vec(SRC_INVSYM);
    chk("tail long", 32'h1, {31'h0, (cyc - t) >= 8 * TICK});
    chk("tail bits", {24'h0, ~b[5:0], 2'b11}, {24'h0, sh_q});
    flag("tx drive", 1'b0, tx_drive);
    bus(1'b1, OFS_CTRL_TWO, 32'h1, rd);
    vec_is(SRC_NONE);
    // Single byte closed by end-of-data
    b = 8'($urandom);
    bus(1'b1, OFS_DATA, {24'h0, b}, rd);
    wait_vec(SRC_TXEMPTY);
    bus(1'b1, OFS_CTRL_TWO, 32'h1, rd);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tx_eod !== 1'b1 && n < 100);
    chk("eod pulse", 32'h1, {31'h0, tx_eod});
    @(negedge clk);
    chk("tx bits", {24'h0, b}, {24'h0, sh_q});
    vec_is(SRC_NONE);
    // Transmitter idle before low power
    bus(1'b1, OFS_CTRL_ONE, 32'h1, rd);
    @(posedge clk);
    cpu_wait_exec <= 1'b1;
    @(posedge clk);
    cpu_wait_exec <= 1'b0;
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    chk("mode", {30'h0, M_WAIT}, {30'h0, rd[5:4]});
    flag("tx drive", 1'b0, tx_drive);
    node.put(mk(2, 8'h00));
    flag("irq", 1'b1, irq_req);
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    chk("mode", {30'h0, M_RUN}, {30'h0, rd[5:4]});
    vec_is(SRC_EOF);
    for (int s = 0; s < 3; s++) begin
      // Third pass: stop while receiver busy, falling edge wakes
      if (s == 2) begin
        node.pin(1'b1);
        node.put(mk(6, 8'h00));
      end
      bus(1'b1, OFS_CTRL_ONE, {30'h0, s[0], 1'b1}, rd);
      @(posedge clk);
      cpu_stop_exec <= (s != 1);
      cpu_wait_exec <= (s == 1);
      @(posedge clk);
      cpu_stop_exec <= 1'b0;
      cpu_wait_exec <= 1'b0;
      flag("clocks", 1'b0, clocks_run);
      flag("irq", 1'b0, irq_req);
      node.pin(s != 2);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (nmi_req !== 1'b1 && n < 20);
      chk("nmi", 32'h1, {31'h0, nmi_req});
      node.pin(1'b0);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("mode", {30'h0, M_WAKE}, {30'h0, rd[5:4]});
      wait_vec(SRC_WAKEUP);
      flag("clocks", 1'b1, clocks_run);
      repeat (STAB_CYC) @(posedge clk);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("mode", {30'h0, M_RUN}, {30'h0, rd[5:4]});
    end
    give_verdict();
  end
endmodule
